// *** pkg/cfvs_pkg.sv ***
package cfvs_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ      = 32'h02faf080;   // 50 MHz module clock
    localparam int MS_PER_S    = 32'h000003e8;
    localparam int LINK_WD_MS  = 32'h000001f4;   // Link watchdog, ms
    localparam int MS_CYC      = CLK_HZ / MS_PER_S;
    localparam int LINK_WD_CYC = MS_CYC * LINK_WD_MS;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_WDTIME = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] CH_BASE     = 12'h040;
    localparam logic [11:0] CH_STRIDE   = 12'h020;
    localparam logic [11:0] OFF_CFG     = 12'h000;
    localparam logic [11:0] OFF_SIM     = 12'h004;
    localparam logic [11:0] OFF_SUBST   = 12'h008;
    localparam logic [11:0] OFF_LO      = 12'h00c;
    localparam logic [11:0] OFF_HI      = 12'h010;
    localparam logic [11:0] OFF_LAST    = 12'h014;

    // ------------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------------
    localparam int CTRL_WD_EN  = 0;
    localparam int ST_ALARM    = 0;
    localparam int ST_BUSFLT   = 1;
    localparam int ST_LINKLOST = 2;
    localparam int CFG_SIM     = 0;
    localparam int CFG_NEG     = 1;
    localparam int CFG_ERR_LO  = 2;
    localparam int CFG_ERR_HI  = 3;
    localparam int CFG_ANALOG  = 4;
    localparam int CFG_OUTPUT  = 5;
    localparam int CFG_W       = 6;

    // ------------------------------------------------------------------
    // Reset values and scaling constants
    // ------------------------------------------------------------------
    localparam logic [15:0] WDTIME_RST = 16'h0064;  // 100 ms
    localparam logic [15:0] LO_RST     = 16'h2710;  // 10000 = 0 %
    localparam logic [15:0] HI_RST     = 16'hc350;  // 50000 = 100 %
    localparam logic [15:0] LIVE0_UA   = 16'h0fa0;  // 4 mA in uA
    localparam logic [15:0] SPAN_UA    = 16'h3e80;  // 16 mA span in uA

    // Error strategy of a channel
    typedef enum logic [1:0] {
        CFVS_ERR_CUR,
        CFVS_ERR_SUB,
        CFVS_ERR_LAST
    } cfvs_err_t;

endpackage

// *** rtl/cfvs_selector.sv ***
`timescale 1ns/1ps

// Summary of operation
// - Each channel runs normal or uses its simulation value.
// - Simulation touches only its own channel.
// - Simulated input reports its simulation value.
// - Simulated output value is processed like bus data.
// - Watchdog expiry or invalid data applies output error mode.
// - Output line faults never start the error mode.
// - Watchdog off: bus failure keeps the old output.
// - Startup fault drives outputs straight to error value.
// - Current mode drives the received value even if invalid.
// - Substitute mode drives the channel substitute value.
// - Last-valid mode drives the last value received valid.
// - Link loss switches outputs off after about 500 ms.
// - Faulty inputs report data per their error mode.
// - Current mode input reports faulty value, invalid.
// - Substitute mode input reports substitute value, invalid.
// - Last-valid input reports last pre-fault value, invalid.
// - Link loss flags inputs invalid and sets alarm bit.
// - Negation inverts digital bit in normal and current mode.
// - Each channel has its own configuration and state.
// - Default analog range 10000 (0 %) to 50000 (100 %).
// - Live zero at 4 mA; value 0 is 0 mA both ways.
// - Range per channel may be 4000..20000 to follow mA.
module cfvs_selector #(
    parameter int N_CH        = 4,
    parameter int MS_CYC      = cfvs_pkg::MS_CYC,
    parameter int LINK_WD_CYC = cfvs_pkg::LINK_WD_CYC
) (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic [11:0]         reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_we,
    input  wire logic                reg_re,
    output logic      [31:0]         reg_rdata,
    input  wire logic                bus_frame_valid,
    input  wire logic [N_CH*16-1:0]  bus_out_data,
    input  wire logic [N_CH-1:0]     bus_out_invalid,
    output logic      [N_CH*16-1:0]  bus_in_data,
    output logic      [N_CH-1:0]     bus_in_invalid,
    input  wire logic                link_alive,
    input  wire logic [N_CH*16-1:0]  field_in_data,
    input  wire logic [N_CH-1:0]     field_in_fault,
    output logic      [N_CH*16-1:0]  field_out_data,
    output logic      [N_CH-1:0]     field_out_en,
    output logic                     link_alarm
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [31:0]                   rdata;
        logic                          wd_en;
        logic [15:0]                   wd_ms;
        logic [31:0]                   ms_div;
        logic [15:0]                   wd_cnt;
        logic                          bus_fault;
        logic [31:0]                   lk_cnt;
        logic                          link_lost;
        logic                          alarm;
        logic [N_CH-1:0][cfvs_pkg::CFG_W-1:0] cfg;
        logic [N_CH-1:0][15:0]         sim;
        logic [N_CH-1:0][15:0]         subst;
        logic [N_CH-1:0][15:0]         lo;
        logic [N_CH-1:0][15:0]         hi;
        logic [N_CH-1:0][15:0]         last;
        logic [N_CH-1:0][15:0]         bus_data;
        logic [N_CH-1:0]               bus_inv;
        logic [N_CH-1:0][15:0]         out_data;
        logic [N_CH-1:0]               out_en;
        logic [N_CH-1:0][15:0]         in_data;
        logic [N_CH-1:0]               in_inv;
    } cfvs_state_t;

    cfvs_state_t st_reg;
    cfvs_state_t st_next;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Byte address of a channel register
    function automatic logic [11:0] cfvs_ch_addr(input int ch,
                                                 input logic [11:0] off);
        logic [11:0] idx;
        idx = 12'(ch);
        return 12'(cfvs_pkg::CH_BASE + idx * cfvs_pkg::CH_STRIDE + off);
    endfunction

    // Clamp a signed result to 16 bits
    function automatic logic [15:0] cfvs_sat(input logic signed [47:0] t);
        logic [15:0] r;
        r = 16'h0;
        if (t > 48'sh00000000ffff)
            r = 16'hffff;
        else if (t >= 48'sh0)
            r = t[15:0];
        return r;
    endfunction

    // Input uA to bus value
    function automatic logic [15:0] cfvs_to_num(input logic [15:0] ua,
                                                input logic [15:0] lo,
                                                input logic [15:0] hi);
        logic signed [47:0] t;
        t = $signed({32'h0, ua}) - $signed({32'h0, cfvs_pkg::LIVE0_UA});
        t = t * ($signed({32'h0, hi}) - $signed({32'h0, lo}));
        t = t / $signed({32'h0, cfvs_pkg::SPAN_UA});
        t = t + $signed({32'h0, lo});
        if (ua == 16'h0)
            return 16'h0;
        return cfvs_sat(t);
    endfunction

    // Bus value to output uA
    function automatic logic [15:0] cfvs_to_ua(input logic [15:0] v,
                                               input logic [15:0] lo,
                                               input logic [15:0] hi);
        logic signed [47:0] t;
        logic signed [47:0] d;
        d = $signed({32'h0, hi}) - $signed({32'h0, lo});
        t = $signed({32'h0, v}) - $signed({32'h0, lo});
        t = t * $signed({32'h0, cfvs_pkg::SPAN_UA});
        // An empty or inverted range drives 0 mA
        if (v == 16'h0 || d <= 48'sh0)
            return 16'h0;
        t = t / d + $signed({32'h0, cfvs_pkg::LIVE0_UA});
        return cfvs_sat(t);
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        logic              ms_tick;
        logic              sim;
        logic              neg;
        logic              ana;
        logic              bad;
        cfvs_pkg::cfvs_err_t mode;
        logic [15:0]       src;
        logic [15:0]       proc;
        logic [15:0]       val;
        logic [15:0]       fin;
        ms_tick = 1'b0;
        sim = 1'b0;
        neg = 1'b0;
        ana = 1'b0;
        bad = 1'b0;
        mode = cfvs_pkg::CFVS_ERR_CUR;
        src = 16'h0;
        proc = 16'h0;
        val = 16'h0;
        fin = 16'h0;
        st_next = st_reg;
        st_next.rdata = 32'h0;

        // Millisecond enable for the bus watchdog
        if (st_reg.ms_div >= 32'(MS_CYC - 1))
        begin
            st_next.ms_div = 32'h0;
            ms_tick = 1'b1;
        end
        else
            st_next.ms_div = st_reg.ms_div + 32'h1;

        // Bus watchdog; a frame restarts it
        if (!st_reg.wd_en)
        begin
            st_next.wd_cnt = 16'h0;
            st_next.bus_fault = 1'b0;
        end
        else if (bus_frame_valid)
        begin
            st_next.wd_cnt = 16'h0;
            st_next.bus_fault = 1'b0;
        end
        else if (ms_tick && !st_reg.bus_fault)
        begin
            st_next.wd_cnt = st_reg.wd_cnt + 16'h1;
            if (st_reg.wd_cnt + 16'h1 >= st_reg.wd_ms)
                st_next.bus_fault = 1'b1;
        end

        // Bus data held until next frame
        if (bus_frame_valid)
        begin
            st_next.bus_data = bus_out_data;
            st_next.bus_inv = bus_out_invalid;
        end

        // Internal link watchdog
        if (link_alive)
        begin
            st_next.lk_cnt = 32'h0;
            st_next.link_lost = 1'b0;
        end
        else if (st_reg.lk_cnt >= 32'(LINK_WD_CYC - 1))
            st_next.link_lost = 1'b1;
        else
            st_next.lk_cnt = st_reg.lk_cnt + 32'h1;

        // Register writes
        if (reg_we)
        begin
            if (reg_addr == cfvs_pkg::ADDR_CTRL)
                st_next.wd_en = reg_wdata[cfvs_pkg::CTRL_WD_EN];
            if (reg_addr == cfvs_pkg::ADDR_WDTIME)
                st_next.wd_ms = reg_wdata[15:0];
            if (reg_addr == cfvs_pkg::ADDR_STATUS &&
                reg_wdata[cfvs_pkg::ST_ALARM])
                st_next.alarm = 1'b0;
            for (int i = 0; i < N_CH; i++)
            begin
                if (reg_addr == cfvs_ch_addr(i, cfvs_pkg::OFF_CFG))
                    st_next.cfg[i] = reg_wdata[cfvs_pkg::CFG_W-1:0];
                if (reg_addr == cfvs_ch_addr(i, cfvs_pkg::OFF_SIM))
                    st_next.sim[i] = reg_wdata[15:0];
                if (reg_addr == cfvs_ch_addr(i, cfvs_pkg::OFF_SUBST))
                    st_next.subst[i] = reg_wdata[15:0];
                if (reg_addr == cfvs_ch_addr(i, cfvs_pkg::OFF_LO))
                    st_next.lo[i] = reg_wdata[15:0];
                if (reg_addr == cfvs_ch_addr(i, cfvs_pkg::OFF_HI))
                    st_next.hi[i] = reg_wdata[15:0];
            end
        end

        // Alarm is sticky; loss of link wins over a clear
        if (st_reg.link_lost)
            st_next.alarm = 1'b1;

        // Reads answer in the next cycle
        if (reg_re)
        begin
            if (reg_addr == cfvs_pkg::ADDR_CTRL)
                st_next.rdata[cfvs_pkg::CTRL_WD_EN] = st_reg.wd_en;
            if (reg_addr == cfvs_pkg::ADDR_WDTIME)
                st_next.rdata[15:0] = st_reg.wd_ms;
            if (reg_addr == cfvs_pkg::ADDR_STATUS)
            begin
                st_next.rdata[cfvs_pkg::ST_ALARM] = st_reg.alarm;
                st_next.rdata[cfvs_pkg::ST_BUSFLT] = st_reg.bus_fault;
                st_next.rdata[cfvs_pkg::ST_LINKLOST] = st_reg.link_lost;
            end
            for (int i = 0; i < N_CH; i++)
            begin
                if (reg_addr == cfvs_ch_addr(i, cfvs_pkg::OFF_CFG))
                    st_next.rdata[cfvs_pkg::CFG_W-1:0] = st_reg.cfg[i];
                if (reg_addr == cfvs_ch_addr(i, cfvs_pkg::OFF_SIM))
                    st_next.rdata[15:0] = st_reg.sim[i];
                if (reg_addr == cfvs_ch_addr(i, cfvs_pkg::OFF_SUBST))
                    st_next.rdata[15:0] = st_reg.subst[i];
                if (reg_addr == cfvs_ch_addr(i, cfvs_pkg::OFF_LO))
                    st_next.rdata[15:0] = st_reg.lo[i];
                if (reg_addr == cfvs_ch_addr(i, cfvs_pkg::OFF_HI))
                    st_next.rdata[15:0] = st_reg.hi[i];
                if (reg_addr == cfvs_ch_addr(i, cfvs_pkg::OFF_LAST))
                    st_next.rdata[15:0] = st_reg.last[i];
            end
        end

        // Per-channel value selection
        for (int i = 0; i < N_CH; i++)
        begin
            sim = st_reg.cfg[i][cfvs_pkg::CFG_SIM];
            neg = st_reg.cfg[i][cfvs_pkg::CFG_NEG];
            ana = st_reg.cfg[i][cfvs_pkg::CFG_ANALOG];
            mode = cfvs_pkg::cfvs_err_t'(
                st_reg.cfg[i][cfvs_pkg::CFG_ERR_HI:cfvs_pkg::CFG_ERR_LO]);
            if (st_reg.cfg[i][cfvs_pkg::CFG_OUTPUT])
            begin
                // Simulation value replaces bus data
                src = sim ? st_reg.sim[i] : st_reg.bus_data[i];
                proc = ana ? src : {15'h0, src[0] ^ neg};
                // Field line faults play no part
                bad = !sim && (st_reg.bus_inv[i] ||
                               st_reg.bus_fault);
                case (mode)
                    cfvs_pkg::CFVS_ERR_CUR:
                        val = proc;
                    cfvs_pkg::CFVS_ERR_SUB:
                        val = bad ? st_reg.subst[i] : proc;
                    cfvs_pkg::CFVS_ERR_LAST:
                        val = bad ? st_reg.last[i] : proc;
                    default:
                        val = proc;
                endcase
                if (!bad)
                    st_next.last[i] = proc;
                fin = ana ? cfvs_to_ua(val, st_reg.lo[i],
                                       st_reg.hi[i]) : val;
                // Value is already the error value
                // when the enable rises after reset
                st_next.out_data[i] = st_reg.link_lost ? 16'h0 : fin;
                st_next.out_en[i] = !st_reg.link_lost;
                st_next.in_data[i] = 16'h0;
                st_next.in_inv[i] = 1'b0;
            end
            else
            begin
                src = field_in_data[i*16 +: 16];
                proc = ana ? cfvs_to_num(src, st_reg.lo[i], st_reg.hi[i])
                           : {15'h0, src[0] ^ neg};
                bad = field_in_fault[i] || st_reg.link_lost;
                if (sim)
                begin
                    st_next.in_data[i] = st_reg.sim[i];
                    st_next.in_inv[i] = st_reg.link_lost;
                end
                else if (bad)
                begin
                    case (mode)
                        cfvs_pkg::CFVS_ERR_CUR:
                            st_next.in_data[i] = proc;
                        cfvs_pkg::CFVS_ERR_SUB:
                            st_next.in_data[i] = st_reg.subst[i];
                        cfvs_pkg::CFVS_ERR_LAST:
                            st_next.in_data[i] = st_reg.last[i];
                        default:
                            st_next.in_data[i] = proc;
                    endcase
                    st_next.in_inv[i] = 1'b1;
                end
                else
                begin
                    st_next.in_data[i] = proc;
                    st_next.in_inv[i] = 1'b0;
                end
                if (!bad)
                    st_next.last[i] = proc;
                st_next.out_data[i] = 16'h0;
                st_next.out_en[i] = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.wd_en <= 1'b1;
            st_reg.wd_ms <= cfvs_pkg::WDTIME_RST;
            // No frame yet counts as a bus fault
            st_reg.bus_fault <= 1'b1;
            for (int i = 0; i < N_CH; i++)
            begin
                st_reg.lo[i] <= cfvs_pkg::LO_RST;
                st_reg.hi[i] <= cfvs_pkg::HI_RST;
            end
        end
        else
            st_reg <= st_next;
    end

    // ------------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------------
    assign reg_rdata      = st_reg.rdata;
    assign bus_in_data    = st_reg.in_data;
    assign bus_in_invalid = st_reg.in_inv;
    assign field_out_data = st_reg.out_data;
    assign field_out_en   = st_reg.out_en;
    assign link_alarm     = st_reg.alarm;

endmodule

// *** dv/cfvs_fieldbus_model.sv ***
`timescale 1ns/1ps

module cfvs_fieldbus_model (
    input  wire logic        clock,
    output logic             bus_frame_valid,
    output logic [63:0]      bus_out_data,
    output logic [3:0]       bus_out_invalid
);
    logic [63:0] d_q  = '0;
    logic [3:0]  i_q  = '0;
    logic [63:0] junk = '0;
    logic        fr   = 1'b0;
    int          seed = 59438;

    // Noise between frames exposes a stale latch
    always @(posedge clock)
        junk <= {$random(seed), $random(seed)};
    assign bus_frame_valid = fr;
    assign bus_out_data    = fr ? d_q : junk;
    assign bus_out_invalid = fr ? i_q : junk[3:0];

    // One-cycle frame
    task automatic send(input logic [63:0] d, input logic [3:0] inv);
        @(posedge clock);
        d_q <= d;
        i_q <= inv;
        fr  <= 1'b1;
        @(posedge clock);
        fr <= 1'b0;
    endtask
endmodule

// *** dv/cfvs_properties.sv ***
`timescale 1ns/1ps

module cfvs_properties #(
    parameter int N_CH        = 4,
    parameter int LINK_WD_CYC = 200
) (
    input wire logic                clock,
    input wire logic                rst_n,
    input wire logic [11:0]         reg_addr,
    input wire logic [31:0]         reg_wdata,
    input wire logic                reg_we,
    input wire logic                bus_frame_valid,
    input wire logic [N_CH-1:0]     bus_in_invalid,
    input wire logic                link_alive,
    input wire logic [N_CH-1:0]     field_in_fault,
    input wire logic [N_CH*16-1:0]  field_out_data,
    input wire logic [N_CH-1:0]     field_out_en,
    input wire logic                link_alarm
);
    logic [N_CH-1:0] out_q, sim_q, in_sim, bad_in, good_in;
    logic            wd_q;
    int              idle;
    logic [3:0]      ok_sr;
    logic            ok, lost;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Margins clear the link timer trip cycle
    assign ok      = &ok_sr;
    assign lost    = idle > LINK_WD_CYC + 2;
    assign in_sim  = ~out_q & sim_q;
    assign bad_in  = ~out_q & ~sim_q & field_in_fault;
    assign good_in = ~out_q & ~sim_q & ~field_in_fault;

    // Shadow of control and channel bits
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wd_q  <= 1'b1;
            idle  <= 0;
            ok_sr <= '0;
            out_q <= '0;
            sim_q <= '0;
        end
        else
        begin
            if (reg_we && reg_addr == cfvs_pkg::ADDR_CTRL)
                wd_q <= reg_wdata[0];
            for (int i = 0; i < N_CH; i++)
                if (reg_we && reg_addr ==
                    cfvs_pkg::CH_BASE + cfvs_pkg::CH_STRIDE * 12'(i))
                begin
                    out_q[i] <= reg_wdata[cfvs_pkg::CFG_OUTPUT];
                    sim_q[i] <= reg_wdata[cfvs_pkg::CFG_SIM];
                end
            idle  <= link_alive ? 0 : (lost ? idle : idle + 1);
            ok_sr <= {ok_sr[2:0], idle < LINK_WD_CYC - 4};
        end
    end

    property p_hold;
        !wd_q && !$past(wd_q, 3) && ok && !$past(bus_frame_valid, 2)
            && !$past(reg_we, 2) |-> $stable(field_out_data);
    endproperty
    a_hold: assert property (p_hold) else $error("output moved");
    property p_en;
        ok |-> field_out_en == $past(out_q);
    endproperty
    a_en: assert property (p_en) else $error("output enable");
    property p_in_sim;
        ok |=> (bus_in_invalid & $past(in_sim)) == '0;
    endproperty
    a_in_sim: assert property (p_in_sim) else $error("sim invalid");
    property p_in_bad;
        ok |=> (bus_in_invalid & $past(bad_in)) == $past(bad_in);
    endproperty
    a_in_bad: assert property (p_in_bad) else $error("fault valid");
    property p_in_good;
        ok |=> (bus_in_invalid & $past(good_in)) == '0;
    endproperty
    a_in_good: assert property (p_in_good) else $error("good invalid");
    property p_link_off;
        lost |-> field_out_en == '0 && field_out_data == '0;
    endproperty
    a_link_off: assert property (p_link_off) else $error("link off");
    property p_link_inv;
        lost |-> &(bus_in_invalid | out_q);
    endproperty
    a_link_inv: assert property (p_link_inv) else $error("link inv");
    property p_alarm;
        lost [*2] |-> link_alarm;
    endproperty
    a_alarm: assert property (p_alarm) else $error("no alarm");
endmodule

bind cfvs_selector cfvs_properties #(
    .N_CH(N_CH), .LINK_WD_CYC(LINK_WD_CYC)) u_props (
    .clock, .rst_n, .reg_addr, .reg_wdata, .reg_we, .bus_frame_valid,
    .bus_in_invalid, .link_alive, .field_in_fault, .field_out_data,
    .field_out_en, .link_alarm
);

// *** dv/tb_channel_fault_value_selector.sv ***
`timescale 1ns/1ps

module tb_channel_fault_value_selector;
    localparam int LWD = 200;
    logic        clock = 1'b0, rst_n = 1'b0, reg_we = 1'b0, reg_re = 1'b0;
    logic [11:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata;
    logic [63:0] bus_out_data, bus_in_data, field_out_data, d;
    logic [63:0] field_in_data = '0;
    logic [3:0]  bus_out_invalid, bus_in_invalid, field_out_en, iv;
    logic [3:0]  field_in_fault = '0;
    logic        bus_frame_valid, link_alarm, link_alive = 1'b0;
    logic        link_stop = 1'b0;
    int          failures = 0, n_compared = 0, seed = 59438, cyc = 0;
    int          md, v, e, lo, hi, lv, bad;

    always #10 clock = ~clock;

    // Heartbeat, well inside link timeout
    always @(posedge clock)
    begin
        cyc        <= cyc + 1;
        link_alive <= !link_stop && (cyc % 40 == 0);
    end

    cfvs_selector #(.N_CH(4), .MS_CYC(10), .LINK_WD_CYC(LWD)) dut (
        .clock, .rst_n, .reg_addr, .reg_wdata, .reg_we, .reg_re,
        .reg_rdata, .bus_frame_valid, .bus_out_data, .bus_out_invalid,
        .bus_in_data, .bus_in_invalid, .link_alive, .field_in_data,
        .field_in_fault, .field_out_data, .field_out_en, .link_alarm);
    cfvs_fieldbus_model fbm (
        .clock, .bus_frame_valid, .bus_out_data, .bus_out_invalid);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] x);
        @(posedge clock);
        reg_we    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= x;
        @(posedge clock);
        reg_we <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_re   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_re <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    // Output lands one edge after frame or write
    task automatic oc(int ch, int exp);
        @(posedge clock);
        #1 chk(32'(field_out_data[16*ch +: 16]), exp);
    endtask
    function automatic logic [11:0] ca(int ch, logic [11:0] off);
        return cfvs_pkg::CH_BASE + cfvs_pkg::CH_STRIDE * 12'(ch) + off;
    endfunction
    // Reference scaling, truncating, clamped
    function automatic int lin(int x, int x0, int y0, int dx, int dy);
        longint r;
        if (x == 0 || dx <= 0)
            return 0;
        r = y0 + longint'(x - x0) * dy / dx;
        return r < 0 ? 0 : (r > 65535 ? 65535 : int'(r));
    endfunction
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd(cfvs_pkg::ADDR_CTRL, 32'h1);
        rd(cfvs_pkg::ADDR_WDTIME, 32'h64);
        rd(cfvs_pkg::ADDR_STATUS, 32'h2);
        rd(ca(0, cfvs_pkg::OFF_HI), 32'hc350);
        rd(12'hffc, 32'h0);
        wr(ca(0, cfvs_pkg::OFF_SUBST), 32'h1);
        wr(ca(0, cfvs_pkg::OFF_CFG), 32'h24);
        oc(0, 1);
        for (int i = 0; i < 8; i++)
        begin
            wr(ca(0, cfvs_pkg::OFF_CFG), 32'h20 | (i & 2));
            d    = {$random(seed), $random(seed)};
            d[0] = i[0];
            iv    = 4'($random(seed));
            iv[0] = i[2];
            fbm.send(d, iv);
            oc(0, (i & 1) ^ ((i >> 1) & 1));
        end
        wr(ca(0, cfvs_pkg::OFF_SIM), 32'h1);
        wr(ca(0, cfvs_pkg::OFF_CFG), 32'h23);
        fbm.send(64'h0, 4'hf);
        oc(0, 0);
        lo = 10000;
        hi = 50000;
        lv = 0;
        wr(ca(1, cfvs_pkg::OFF_SUBST), 32'd20000);
        for (int k = 0; k < 12; k++)
        begin
            if (k == 6)
            begin
                lo = 4000;
                hi = 20000;
                wr(ca(1, cfvs_pkg::OFF_LO), 32'(lo));
                wr(ca(1, cfvs_pkg::OFF_HI), 32'(hi));
            end
            md  = k % 3;
            v   = k == 3 ? 0 : lo + $unsigned($random(seed)) % (hi - lo + 1);
            bad = k > 0 && ($random(seed) & 1);
            e   = bad && md == 1 ? 20000 : (bad && md == 2 ? lv : v);
            if (!bad)
                lv = v;
            wr(ca(1, cfvs_pkg::OFF_CFG), 32'h30 | md << 2);
            d         = {$random(seed), $random(seed)};
            d[31:16]  = 16'(v);
            iv        = 4'($random(seed));
            iv[1]     = 1'(bad);
            fbm.send(d, iv);
            oc(1, lin(e, lo, 4000, hi - lo, 16000));
        end
        lo = 10000;
        hi = 50000;
        wr(ca(2, cfvs_pkg::OFF_SUBST), 32'd33333);
        for (int k = 0; k < 9; k++)
        begin
            md = k % 3;
            wr(ca(2, cfvs_pkg::OFF_CFG), 32'h10 | md << 2);
            v   = k == 1 ? 0 : 4000 + $unsigned($random(seed)) % 16001;
            bad = k > 0 && ($random(seed) & 1);
            e   = lin(v, 4000, lo, 16000, hi - lo);
            if (!bad)
                lv = e;
            e = bad && md == 1 ? 33333 : (bad && md == 2 ? lv : e);
            @(posedge clock);
            field_in_data[47:32] <= 16'(v);
            field_in_fault[2]    <= 1'(bad);
            @(posedge clock);
            #1 chk(32'(bus_in_data[47:32]), e);
            chk(32'(bus_in_invalid[2]), bad);
        end
        @(posedge clock);
        field_in_fault[2] <= 1'b1;
        wr(ca(2, cfvs_pkg::OFF_SIM), 32'd12345);
        wr(ca(2, cfvs_pkg::OFF_CFG), 32'h11);
        @(posedge clock);
        #1 chk(32'(bus_in_data[47:32]), 12345);
        chk(32'(bus_in_invalid[2]), 0);
        wr(ca(0, cfvs_pkg::OFF_CFG), 32'h24);
        wr(cfvs_pkg::ADDR_WDTIME, 32'h5);
        fbm.send(64'h0, 4'h0);
        oc(0, 0);
        repeat (30) @(posedge clock);
        oc(0, 0);
        repeat (40) @(posedge clock);
        oc(0, 1);
        rd(cfvs_pkg::ADDR_STATUS, 32'h2);
        wr(cfvs_pkg::ADDR_CTRL, 32'h0);
        fbm.send(64'h0, 4'h0);
        repeat (80) @(posedge clock);
        oc(0, 0);
        link_stop <= 1'b1;
        repeat (LWD + 60) @(posedge clock);
        #1 chk(32'(field_out_en), 0);
        chk(field_out_data[31:0], 0);
        chk(32'(bus_in_invalid), 32'hc);
        rd(cfvs_pkg::ADDR_STATUS, 32'h5);
        link_stop <= 1'b0;
        repeat (60) @(posedge clock);
        wr(cfvs_pkg::ADDR_STATUS, 32'h1);
        rd(cfvs_pkg::ADDR_STATUS, 32'h0);
        chk(32'(field_out_en), 32'h3);
        finish_test();
    end

    // Hang guard, well past the run length
    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        finish_test();
    end
endmodule
